// >>> sim/ephr_host_regs_sva.sv
// checker: bus handshakes and eeprom start timing of the host registers
`timescale 1ns/1ps
module ephr_host_regs_chk
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        nrst_i,
  // axi4-lite
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // eeprom engine
  input wire logic        eeprom_start_o
);
  import ephr_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_b_answer;
    s_wr_taken |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write response late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_answer;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read data late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("second write accepted");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("second read accepted");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read gave data");
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read half not zero");
  property p_start_pulse;
    eeprom_start_o |=> !eeprom_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_start_cause;
    eeprom_start_o |-> $rose(s_axi_bvalid) && s_axi_bresp == RESP_OKAY;
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without write");
endmodule

bind ephr_host_regs ephr_host_regs_chk ephr_host_regs_chk_i
(
  .clk_i, .nrst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .eeprom_start_o
);

// >>> sim/ephr_port_model.sv
// model: eeprom engine answering read commands with a word
`timescale 1ns/1ps
module ephr_port_model
#(
  parameter logic [1:0]  RD_OP   = 2'h2,
  parameter logic [15:0] RD_BASE = 16'hC300
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // command side
  input  wire logic        start_i,
  input  wire logic [1:0]  opcode_i,
  input  wire logic [7:0]  addr_i,
  // answer
  output logic             valid_o,
  output logic [15:0]      data_o
);
  // data toggles when idle so a stale word is never mistaken for an answer
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      valid_o <= 1'b0;
      data_o  <= 16'h5A5A;
    end
    else
    begin
      valid_o <= start_i && opcode_i == RD_OP;
      data_o  <= (start_i && opcode_i == RD_OP) ? (RD_BASE | {8'h00, addr_i}) : ~data_o;
    end
endmodule

// >>> sim/tb_ephr_host_regs.sv
// testbench: host registers driven over axi4-lite
`timescale 1ns/1ps
module tb_ephr_host_regs;
  import ephr_pkg::*;
  logic clk_i = 0, nrst_i = 0;
  logic awv = 0, awr, wv = 0, wr, bv, br = 0, arv = 0, arr, rv, rr = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0] ws = 0;
  logic [1:0] bresp, rresp, op;
  logic [4:0] ev = 0;
  logic [9:0] evb [5];
  logic fs = 0, rb = 0, ee_st, ee_v, irq;
  logic [7:0] ee_a;
  logic [15:0] ee_d, ee_rd;
  logic [31:0] got, gr;
  logic [5:0] nums [5] = '{6'h04, 6'h08, 6'h0C, 6'h10, 6'h12};
  int failures = 0, n_tests = 0, cyc = 0;
  always #50 clk_i = ~clk_i;
  ephr_host_regs ephr_host_regs_i (.clk_i, .nrst_i,
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .receive_event_report_i(ev[0]), .receive_event_bits_i(evb[0]),
    .transmit_event_report_i(ev[1]), .transmit_event_bits_i(evb[1]),
    .buffer_event_report_i(ev[2]), .buffer_event_bits_i(evb[2]),
    .missed_frame_counter_i(ev[3]), .missed_frame_bits_i(evb[3]),
    .collision_counter_i(ev[4]), .collision_bits_i(evb[4]),
    .rx_frame_start_i(fs), .rx_byte_i(rb), .eeprom_start_o(ee_st), .eeprom_opcode_o(op),
    .eeprom_word_address_o(ee_a), .eeprom_word_data_o(ee_d),
    .eeprom_read_valid_i(ee_v), .eeprom_read_data_i(ee_rd), .irq_o(irq));
  ephr_port_model ephr_port_model_i (.clk_i, .nrst_i, .start_i(ee_st), .opcode_i(op),
    .addr_i(ee_a), .valid_o(ee_v), .data_o(ee_rd));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    awv <= 1; wv <= 1; br <= 1; awa <= a; wd <= d; ws <= s;
    forever
    begin
      @(posedge clk_i);
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
      if (bv)
      begin
        br <= 0;
        chk("bresp", 32'(RESP_OKAY), 32'(bresp));
        break;
      end
    end
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    arv <= 1; rr <= 1; ara <= a;
    forever
    begin
      @(posedge clk_i);
      if (arv && arr) arv <= 0;
      if (rv)
      begin
        d = rd; r = rresp; rr <= 0;
        break;
      end
    end
  endtask
  task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [1:0] r;
    axr(a, got, r);
    chk(name, exp, got);
  endtask
  task automatic bytes(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      rb <= 1; fs <= (i == 0);
    end
    @(posedge clk_i);
    rb <= 0; fs <= 0;
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      results();
    end
  end
  initial
  begin
    logic [1:0] r;
    for (int k = 0; k < 5; k++) evb[k] = 10'h201 + 10'(k) * 10'h0C3;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1;
    rdc("enable", 12'h088, 32'h0004);
    rdc("queue", 12'h480, 32'h0);
    axr(12'h004, got, r);
    chk("unmapped", 32'h2, 32'(r));
    for (int o = 0; o < 4; o++)
    begin
      axw(12'h100, 32'(o) << 8 | 32'h30 + 32'(o), 4'hF);
      chk("opcode", 32'(o), 32'(op));
      chk("eeaddr", 32'h30 + 32'(o), 32'(ee_a));
      rdc("command", 12'h100, 32'(o) << 8 | 32'h30 + 32'(o));
    end
    rdc("eeread", 12'h108, 32'hC332);
    axw(12'h108, 32'h1234, 4'hF);
    axw(12'h108, 32'hBEEF, 4'h1);
    rdc("eedata", 12'h108, 32'h12EF);
    chk("eeport", 32'h12EF, 32'(ee_d));
    bytes(300);
    rdc("count", 12'h140, 32'h012C);
    bytes(3);
    rdc("restart", 12'h140, 32'h0003);
    axw(12'h480, 32'hFFFF, 4'hF);
    rdc("ro", 12'h480, 32'h0);
    axw(12'h088, 32'h0, 4'hF);
    pulse(5'h1F);
    chk("irq", 32'h1, 32'(irq));
    for (int k = 0; k < 5; k++)
    begin
      axr(k % 2 ? 12'h020 : 12'h480, got, r);
      chk("report", {16'h0, evb[k], nums[k]}, got);
    end
    rdc("empty", 12'h020, 32'h0);
    @(posedge clk_i);
    chk("irqoff", 32'h0, 32'(irq));
    axw(12'h088, 32'h0007, 4'hF);
    pulse(5'h02);
    chk("masked", 32'h0, 32'(irq));
    axr(12'h088, gr, r);
    chk("disbit", 32'h1, 32'(gr[2]));
    axw(12'h088, 32'h0, 4'hF);
    repeat (2) @(posedge clk_i);
    chk("unmask", 32'h1, 32'(irq));
    rdc("tx", 12'h480, {16'h0, evb[1][9:2], evb[1][1:0], 6'h08});
    results();
  end
endmodule

// >>> src/ephr_byte_counter.sv
// module: receive frame byte counter, restarted at each frame
`timescale 1ns/1ps
module ephr_byte_counter
#(
  parameter int unsigned WIDTH = 16
)
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // receive logic
  input  wire logic             frame_start_i,
  input  wire logic             byte_i,
  // count
  output logic [WIDTH-1:0]      count_o
);
  import ephr_pkg::*;

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] base;

  // a byte in the start cycle is the first byte of the new frame
  assign base    = frame_start_i ? '0 : count_q;
  assign count_d = byte_i ? base + WIDTH'(1) : base;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      count_q <= COUNT_RST[WIDTH-1:0];
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign count_o = count_q;
endmodule

// >>> src/ephr_event_queue.sv
// module: pending event reports of the five sources, presented one at a time
`timescale 1ns/1ps
module ephr_event_queue
(
  // clock and reset
  input  wire logic                                          clk_i,
  input  wire logic                                          nrst_i,
  // event inputs from port logic
  input  wire logic [ephr_pkg::NUM_SOURCES-1:0]              event_i,
  input  wire logic [ephr_pkg::NUM_SOURCES-1:0][ephr_pkg::SRC_DATA_W-1:0] event_bits_i,
  // host side
  input  wire logic                                          pop_i,
  output logic [15:0]                                        head_o,
  output logic                                               pending_o
);
  import ephr_pkg::*;

  logic [NUM_SOURCES-1:0]                 pend_q;
  logic [NUM_SOURCES-1:0][SRC_DATA_W-1:0] bits_q;
  logic [NUM_SOURCES-1:0]                 sel;
  logic [15:0]                            head;

  // fixed order: lowest source first, so receive reports are never starved
  always_comb
  begin
    sel  = '0;
    head = QUEUE_RST;
    for (int i = NUM_SOURCES - 1; i >= 0; i--)
    begin
      if (pend_q[i])
      begin
        sel  = '0;
        sel[i] = 1'b1;
        head = {bits_q[i][9:2], bits_q[i][1:0], SRC_NUMBERS[i]};
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SOURCES; g++)
    begin : g_src
      logic clr;
      assign clr = pop_i & sel[g];
      // a new event in the pop cycle stays pending
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          pend_q[g] <= 1'b0;
          bits_q[g] <= '0;
        end
        else
        begin
          pend_q[g] <= (pend_q[g] & ~clr) | event_i[g];
          bits_q[g] <= (clr ? '0 : bits_q[g]) | (event_i[g] ? event_bits_i[g] : '0);
        end
      end
    end
  endgenerate

  assign head_o    = head;
  assign pending_o = |pend_q;
endmodule

// >>> src/ephr_host_regs.sv
// module: ethernet port host registers behind an axi4-lite slave
//
// What this block does
// - a zero interrupt code enables port interrupts, a code with bit 2 set disables them.
// - after reset port interrupts are disabled and the enable register low bits read 100.
// - eeprom command bits 7:0 give the eeprom word address.
// - eeprom command bits 9:8 give the eeprom opcode.
// - eeprom data holds the sixteen-bit word with low byte at the lower address.
// - the receive byte counter counts bytes of the current frame as they arrive.
// - the byte count reads as sixteen bits, least significant byte at the lower address.
// - an event sets its source register bits, is queued for report and raises the request.
// - the queue carries only receive, transmit, buffer, missed-frame and collision reports.
// - queue bits 5:0 give the source register number 4, 8, C, 10 or 12.
// - queue bits 7:6 and 15:8 carry the source register contents.
// - the queue also reads at a second offset with the same content.
// - after reset the queue reads zero.
// - receive reports carry number 4.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module ephr_host_regs
(
  // clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                nrst_i,
  // axi4-lite write address
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [ephr_pkg::ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic [2:0]                          s_axi_awprot,
  // axi4-lite write data
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  // axi4-lite write response
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  output logic [1:0]                               s_axi_bresp,
  // axi4-lite read address
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  input  wire logic [ephr_pkg::ADDR_W-1:0]         s_axi_araddr,
  input  wire logic [2:0]                          s_axi_arprot,
  // axi4-lite read data
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  // event reports from receive, transmit and buffer logic
  input  wire logic                                receive_event_report_i,
  input  wire logic [ephr_pkg::SRC_DATA_W-1:0]     receive_event_bits_i,
  input  wire logic                                transmit_event_report_i,
  input  wire logic [ephr_pkg::SRC_DATA_W-1:0]     transmit_event_bits_i,
  input  wire logic                                buffer_event_report_i,
  input  wire logic [ephr_pkg::SRC_DATA_W-1:0]     buffer_event_bits_i,
  input  wire logic                                missed_frame_counter_i,
  input  wire logic [ephr_pkg::SRC_DATA_W-1:0]     missed_frame_bits_i,
  input  wire logic                                collision_counter_i,
  input  wire logic [ephr_pkg::SRC_DATA_W-1:0]     collision_bits_i,
  // receive byte stream
  input  wire logic                                rx_frame_start_i,
  input  wire logic                                rx_byte_i,
  // eeprom engine
  output logic                                     eeprom_start_o,
  output logic [ephr_pkg::EE_OP_W-1:0]             eeprom_opcode_o,
  output logic [ephr_pkg::EE_ADDR_W-1:0]           eeprom_word_address_o,
  output logic [15:0]                              eeprom_word_data_o,
  input  wire logic                                eeprom_read_valid_i,
  input  wire logic [15:0]                         eeprom_read_data_i,
  // interrupt request pin
  output logic                                     irq_o
);
  import ephr_pkg::*;

  // write channel state
  logic                    awready_q;
  logic                    wready_q;
  logic                    aw_held_q;
  logic                    w_held_q;
  logic [ADDR_W-1:0]       waddr_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  // read channel state
  logic                    arready_q;
  logic                    rvalid_q;
  logic [31:0]             rdata_q;
  logic [1:0]              rresp_q;
  // registers
  logic [15:0]             int_enable_q;
  logic [15:0]             int_enable_d;
  logic [15:0]             ee_cmd_q;
  logic [15:0]             ee_cmd_d;
  logic [15:0]             ee_data_q;
  logic [15:0]             ee_data_d;
  logic                    ee_start_q;
  logic                    irq_q;

  // handshakes
  wire aw_hs = s_axi_awvalid & awready_q;
  wire w_hs  = s_axi_wvalid & wready_q;
  wire b_hs  = bvalid_q & s_axi_bready;
  wire ar_hs = s_axi_arvalid & arready_q;
  wire r_hs  = rvalid_q & s_axi_rready;

  // the write happens once both halves are held and no response is pending
  wire do_write = aw_held_q & w_held_q & ~bvalid_q;

  // register write strobes, one cycle each
  wire int_en_wr  = do_write & wsel_int;
  wire ee_cmd_wr  = do_write & wsel_cmd;
  wire ee_data_wr = do_write & wsel_data;

  // write decode
  wire [IDX_W-1:0] widx   = waddr_q[ADDR_W-1:2];
  wire wsel_int           = (widx == IDX_PORT_INT_ENABLE);
  wire wsel_cmd           = (widx == IDX_EEPROM_COMMAND);
  wire wsel_data          = (widx == IDX_EEPROM_DATA);
  wire wsel_count         = (widx == IDX_RX_BYTE_COUNT);
  wire wsel_queue         = (widx == IDX_EVENT_QUEUE) | (widx == IDX_EVENT_QUEUE_ALT);
  wire wmapped            = wsel_int | wsel_cmd | wsel_data | wsel_count | wsel_queue;

  // read-only registers ignore writes but answer okay
  wire [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // read decode
  wire [IDX_W-1:0] ridx   = s_axi_araddr[ADDR_W-1:2];
  wire rsel_int           = (ridx == IDX_PORT_INT_ENABLE);
  wire rsel_cmd           = (ridx == IDX_EEPROM_COMMAND);
  wire rsel_data          = (ridx == IDX_EEPROM_DATA);
  wire rsel_count         = (ridx == IDX_RX_BYTE_COUNT);
  wire rsel_queue         = (ridx == IDX_EVENT_QUEUE) | (ridx == IDX_EVENT_QUEUE_ALT);
  wire rmapped            = rsel_int | rsel_cmd | rsel_data | rsel_count | rsel_queue;

  // event sources; nothing else feeds the queue
  logic [NUM_SOURCES-1:0]                 ev_valid;
  logic [NUM_SOURCES-1:0][SRC_DATA_W-1:0] ev_bits;
  logic [15:0]                            queue_head;
  logic                                   queue_pending;
  logic [15:0]                            byte_count;

  assign ev_valid[SRC_RX]   = receive_event_report_i;
  assign ev_valid[SRC_TX]   = transmit_event_report_i;
  assign ev_valid[SRC_BUF]  = buffer_event_report_i;
  assign ev_valid[SRC_MISS] = missed_frame_counter_i;
  assign ev_valid[SRC_COL]  = collision_counter_i;
  assign ev_bits[SRC_RX]    = receive_event_bits_i;
  assign ev_bits[SRC_TX]    = transmit_event_bits_i;
  assign ev_bits[SRC_BUF]   = buffer_event_bits_i;
  assign ev_bits[SRC_MISS]  = missed_frame_bits_i;
  assign ev_bits[SRC_COL]   = collision_bits_i;

  // a queue read takes the report it returns off the queue
  wire queue_pop = ar_hs & rsel_queue;

  ephr_event_queue u_queue
  (
    .clk_i        (clk_i),
    .nrst_i       (nrst_i),
    .event_i      (ev_valid),
    .event_bits_i (ev_bits),
    .pop_i        (queue_pop),
    .head_o       (queue_head),
    .pending_o    (queue_pending)
  );

  ephr_byte_counter #(.WIDTH(16)) u_count
  (
    .clk_i         (clk_i),
    .nrst_i        (nrst_i),
    .frame_start_i (rx_frame_start_i),
    .byte_i        (rx_byte_i),
    .count_o       (byte_count)
  );

  // read mux; bits above the sixteen-bit registers read as zero
  wire [15:0] rmux =
    rsel_int   ? int_enable_q :
    rsel_cmd   ? ee_cmd_q     :
    rsel_data  ? ee_data_q    :
    rsel_count ? byte_count   :
    rsel_queue ? queue_head   :
                 16'h0000;

  // register next values
  assign int_enable_d = int_en_wr ?
                        (int_enable_q & ~wmask) | (wdata_q[15:0] & wmask) : int_enable_q;
  // reserved command bits are not stored, so they read back zero whatever the host wrote
  assign ee_cmd_d     = ee_cmd_wr ?
                        ((ee_cmd_q & ~wmask) | (wdata_q[15:0] & wmask)) & EE_CMD_MASK
                        : ee_cmd_q;
  // a word returned by the eeprom engine wins over a host write in the same cycle
  assign ee_data_d    = eeprom_read_valid_i ? eeprom_read_data_i :
                        ee_data_wr ?
                        (ee_data_q & ~wmask) | (wdata_q[15:0] & wmask) : ee_data_q;

  // request pin follows pending reports while the enable code has bit 2 clear
  wire irq_d = queue_pending & ~int_enable_q[INT_DISABLE_BIT];

  // write address channel
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      awready_q <= 1'b1;
      aw_held_q <= 1'b0;
      waddr_q   <= '0;
    end
    else if (aw_hs)
    begin
      awready_q <= 1'b0;
      aw_held_q <= 1'b1;
      waddr_q   <= s_axi_awaddr;
    end
    else if (b_hs)
    begin
      awready_q <= 1'b1;
      aw_held_q <= 1'b0;
    end
  end

  // write data channel
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wready_q <= 1'b1;
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else if (w_hs)
    begin
      wready_q <= 1'b0;
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end
    else if (b_hs)
    begin
      wready_q <= 1'b1;
      w_held_q <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wmapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (b_hs)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel: data is captured at the address handshake
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {16'h0000, rmux};
      rresp_q   <= rmapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (r_hs)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // registers
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      int_enable_q <= INT_ENABLE_RST;
      ee_cmd_q     <= EE_CMD_RST;
      ee_data_q    <= EE_DATA_RST;
    end
    else
    begin
      int_enable_q <= int_enable_d;
      ee_cmd_q     <= ee_cmd_d;
      ee_data_q    <= ee_data_d;
    end
  end

  // command launch pulse, one cycle after the command write
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ee_start_q <= 1'b0;
    end
    else
    begin
      ee_start_q <= ee_cmd_wr;
    end
  end

  // request pin is a flop so it cannot glitch while the queue changes
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  // outputs
  assign s_axi_awready         = awready_q;
  assign s_axi_wready          = wready_q;
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_arready         = arready_q;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rdata           = rdata_q;
  assign s_axi_rresp           = rresp_q;
  assign eeprom_start_o        = ee_start_q;
  assign eeprom_opcode_o       = ee_cmd_q[EE_OP_LSB +: EE_OP_W];
  assign eeprom_word_address_o = ee_cmd_q[EE_ADDR_LSB +: EE_ADDR_W];
  assign eeprom_word_data_o    = ee_data_q;
  assign irq_o                 = irq_q;
endmodule

// >>> src/ephr_pkg.sv
// package: register map, field layout and reset values of the ethernet port host registers
package ephr_pkg;

  // printed offsets are register indexes; byte address is four times the index
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 10;
  localparam logic [IDX_W-1:0] IDX_PORT_INT_ENABLE = 10'h022;
  localparam logic [IDX_W-1:0] IDX_EEPROM_COMMAND  = 10'h040;
  localparam logic [IDX_W-1:0] IDX_EEPROM_DATA     = 10'h042;
  localparam logic [IDX_W-1:0] IDX_RX_BYTE_COUNT   = 10'h050;
  localparam logic [IDX_W-1:0] IDX_EVENT_QUEUE     = 10'h120;
  localparam logic [IDX_W-1:0] IDX_EVENT_QUEUE_ALT = 10'h008;

  // master interrupt enable field
  localparam int unsigned     INT_DISABLE_BIT = 2;
  localparam logic [15:0]     INT_ENABLE_RST  = 16'h0004;

  // eeprom command fields
  localparam int unsigned     EE_ADDR_LSB = 0;
  localparam int unsigned     EE_ADDR_W   = 8;
  localparam int unsigned     EE_OP_LSB   = 8;
  localparam int unsigned     EE_OP_W     = 2;
  localparam logic [15:0]     EE_CMD_MASK = 16'h03FF;
  localparam logic [15:0]     EE_CMD_RST  = 16'h0000;
  localparam logic [15:0]     EE_DATA_RST = 16'h0000;

  // event report layout
  localparam int unsigned     NUM_SOURCES = 5;
  localparam int unsigned     SRC_NUM_W   = 6;
  localparam int unsigned     SRC_DATA_W  = 10;
  localparam logic [15:0]     QUEUE_RST   = 16'h0000;
  localparam logic [15:0]     COUNT_RST   = 16'h0000;

  // source numbers: receive, transmit, buffer, missed frames, collisions
  localparam logic [NUM_SOURCES-1:0][SRC_NUM_W-1:0] SRC_NUMBERS =
    {6'h12, 6'h10, 6'h0C, 6'h08, 6'h04};
  localparam int unsigned     SRC_RX   = 0;
  localparam int unsigned     SRC_TX   = 1;
  localparam int unsigned     SRC_BUF  = 2;
  localparam int unsigned     SRC_MISS = 3;
  localparam int unsigned     SRC_COL  = 4;

  // axi responses
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;

endpackage
